//--- bench/hs_hbw_iso_in_pid_checker_tb.sv
// self-checking bench for the high-bandwidth isochronous in sequence checker
`timescale 1ns/1ps
module hs_hbw_iso_in_pid_checker_tb
	import hbw_iso_pkg::*;
;
	localparam logic [10:0] FULL = 11'h040;
	localparam logic [10:0] SHORT = 11'h010;
	localparam logic [10:0] OVER = 11'h041;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pready, pslverr, in_token, td_advance, rsp_valid, rsp_timeout;
	logic [31:0] prdata;
	logic [2:0] completion_code;
	logic [3:0] rsp_pid;
	logic [10:0] rsp_len;
	logic uframe_start = 1'b0;
	logic [3:0] gap = 4'h1;
	logic [1:0] tmo_at = 2'h3;
	logic [11:0] pid_seq = 12'h000;
	logic [32:0] len_seq = 33'h0;
	logic [31:0] rd_data;
	logic rd_err;
	int errors = 0;
	int n_checks = 0;

	hs_hbw_iso_in_pid_checker hs_hbw_iso_in_pid_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .uframe_start(uframe_start), .in_token(in_token), .rsp_valid(rsp_valid),
		.rsp_pid(rsp_pid), .rsp_len(rsp_len), .rsp_timeout(rsp_timeout), .td_advance(td_advance),
		.completion_code(completion_code));
	iso_ep_model iso_ep_model_inst (.pclk(pclk), .presetn(presetn), .uframe_start(uframe_start),
		.in_token(in_token), .gap(gap), .tmo_at(tmo_at), .pid_seq(pid_seq), .len_seq(len_seq),
		.rsp_valid(rsp_valid), .rsp_pid(rsp_pid), .rsp_len(rsp_len), .rsp_timeout(rsp_timeout));

	// 20 MHz clock
	always #25 pclk = ~pclk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] ctrl_word(input logic en, input logic [1:0] b, input logic [10:0] mp);
		return (32'(mp) << CTRL_MAXPKT_LSB) | (32'(b) << CTRL_BURST_LSB) | 32'(en);
	endfunction

	// configure while disabled, enable, arm, then run one microframe and judge its end
	task automatic run_uf(input logic [1:0] b, input logic [11:0] pids, input logic [32:0] lens,
		input logic [1:0] tm, input int ntok, input logic [2:0] code);
		int tok;
		int k;
		tok = 0;
		k = 0;
		apb(1'b1, CTRL_OFFSET, ctrl_word(1'b0, b, FULL));
		apb(1'b1, CTRL_OFFSET, ctrl_word(1'b1, b, FULL));
		apb(1'b1, ARM_OFFSET, 32'h0000_0001);
		pid_seq <= pids;
		len_seq <= lens;
		tmo_at <= tm;
		uframe_start <= 1'b1;
		@(posedge pclk);
		uframe_start <= 1'b0;
		do
		begin
			#1;
			if (in_token === 1'b1)
				tok++;
			if (td_advance === 1'b1)
				break;
			@(posedge pclk);
			k++;
		end while (k < 200);
		check("advance", 32'(td_advance), 32'h1);
		check("tokens", tok, ntok);
		check("code", 32'(completion_code), 32'(code));
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check("status active", 32'(rd_data[STATUS_ACTIVE_BIT]), 32'h0);
		check("status code", 32'(rd_data[STATUS_CODE_LSB +: 3]), 32'(code));
	endtask

	// reset values, unmapped access, config frozen while enabled
	task automatic t_regs;
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check("ctrl reset", rd_data, ctrl_word(1'b0, BURST_RESET, MAXPKT_RESET));
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", 32'(rd_err), 32'h1);
		check("unmapped data", rd_data, 32'h0);
		apb(1'b1, CTRL_OFFSET, ctrl_word(1'b1, 2'h3, FULL));
		apb(1'b1, CTRL_OFFSET, ctrl_word(1'b1, 2'h1, SHORT));
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check("ctrl frozen", rd_data, ctrl_word(1'b1, 2'h3, FULL));
	endtask

	task automatic t_normal;
		gap <= 4'h1;
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {SHORT, FULL, FULL}, 2'h3, 3, CODE_SUCCESS);
		gap <= 4'h5;
		run_uf(2'h2, {PID_DATA0, PID_DATA0, PID_DATA1}, {FULL, FULL, FULL}, 2'h3, 2, CODE_SUCCESS);
	endtask

	task automatic t_start;
		gap <= 4'h2;
		run_uf(2'h3, {PID_DATA1, PID_DATA1, PID_DATA0}, {FULL, FULL, FULL}, 2'h3, 1, CODE_SUCCESS);
		run_uf(2'h3, {PID_DATA0, PID_DATA0, PID_DATA1}, {FULL, FULL, SHORT}, 2'h3, 1, CODE_TRANSACTION_ERROR);
		run_uf(2'h2, {PID_DATA0, PID_DATA1, PID_DATA2}, {FULL, FULL, SHORT}, 2'h3, 1, CODE_TRANSACTION_ERROR);
		run_uf(2'h1, {PID_DATA0, PID_DATA0, PID_DATA1}, {FULL, FULL, FULL}, 2'h3, 1, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA0, PID_DATA0, PID_DATA0}, {FULL, FULL, OVER}, 2'h3, 1, CODE_BABBLE);
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {FULL, FULL, OVER}, 2'h3, 1, CODE_BABBLE);
		// out-of-range pid wins over oversize payload
		run_uf(2'h2, {PID_DATA0, PID_DATA0, PID_DATA2}, {FULL, FULL, OVER}, 2'h3, 1, CODE_TRANSACTION_ERROR);
		// a non-data pid is never an acceptable first response
		run_uf(2'h3, {PID_DATA0, PID_DATA0, 4'hF}, {FULL, FULL, FULL}, 2'h3, 1, CODE_TRANSACTION_ERROR);
	endtask

	task automatic t_next;
		gap <= 4'h1;
		run_uf(2'h3, {PID_DATA0, PID_DATA2, PID_DATA2}, {FULL, FULL, FULL}, 2'h3, 2, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA0, PID_DATA0, PID_DATA2}, {FULL, SHORT, FULL}, 2'h3, 2, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA1, PID_DATA1, PID_DATA2}, {FULL, FULL, FULL}, 2'h3, 3, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA2, PID_DATA1, PID_DATA2}, {FULL, FULL, FULL}, 2'h3, 3, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {FULL, SHORT, FULL}, 2'h3, 2, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {FULL, OVER, FULL}, 2'h3, 2, CODE_BABBLE);
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {OVER, FULL, FULL}, 2'h3, 3, CODE_BABBLE);
	endtask

	// a timeout on the first and on a follow-on transaction
	task automatic t_timeout;
		gap <= 4'h3;
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {FULL, FULL, FULL}, 2'h0, 1, CODE_TRANSACTION_ERROR);
		run_uf(2'h3, {PID_DATA0, PID_DATA1, PID_DATA2}, {FULL, FULL, FULL}, 2'h1, 2, CODE_TRANSACTION_ERROR);
	endtask

	// running totals: 19 advances so far, 16 of them with an error code
	task automatic t_totals;
		apb(1'b0, COUNT_OFFSET, 32'h0);
		check("count word", rd_data, 32'h0010_0013);
	endtask

	// main sequence after eight cycles of reset
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_normal();
		t_start();
		t_next();
		t_timeout();
		t_totals();
		close_out();
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		close_out();
	end
endmodule // hs_hbw_iso_in_pid_checker_tb

//--- bench/iso_ep_model.sv
// far-side isochronous in endpoint model answering tokens from a script
`timescale 1ns/1ps
module iso_ep_model
	import hbw_iso_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic uframe_start,
	input wire logic in_token,
	input wire logic [3:0] gap,
	input wire logic [1:0] tmo_at,
	input wire logic [11:0] pid_seq,
	input wire logic [32:0] len_seq,
	output logic rsp_valid,
	output logic [3:0] rsp_pid,
	output logic [MAXPKT_WIDTH-1:0] rsp_len,
	output logic rsp_timeout
);
	logic [3:0] wcnt;
	logic [1:0] idx;

	// answer gap cycles after each token; lines toggle when idle so stale data never looks valid
	// scripted start and step
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wcnt <= 4'h0;
			idx <= 2'h0;
			rsp_valid <= 1'b0;
			rsp_timeout <= 1'b0;
			rsp_pid <= 4'h0;
			rsp_len <= 11'h000;
		end
		else
		begin
			rsp_valid <= 1'b0;
			rsp_timeout <= 1'b0;
			if (wcnt == 4'h1)
			begin
				idx <= idx + 2'h1;
				if (idx == tmo_at)
					rsp_timeout <= 1'b1;
				else
				begin
					rsp_valid <= 1'b1;
					rsp_pid <= pid_seq[idx*4 +: 4];
					rsp_len <= len_seq[idx*11 +: 11];
				end
			end
			else
			begin
				rsp_pid <= ~rsp_pid;
				rsp_len <= ~rsp_len;
			end
			if (in_token)
				wcnt <= gap;
			else if (wcnt != 4'h0)
				wcnt <= wcnt - 4'h1;
			if (uframe_start)
				idx <= 2'h0;
		end
	end
endmodule // iso_ep_model

//--- hdl/hbw_iso_regs.sv
// apb register slave: configuration, arming and status read-back
`timescale 1ns/1ps
module hbw_iso_regs
	import hbw_iso_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic hw_clear_active,
	input wire logic [31:0] status_word,
	input wire logic [31:0] count_word,
	output logic enable,
	output logic [BURST_WIDTH-1:0] burst,
	output logic [MAXPKT_WIDTH-1:0] max_packet,
	output logic active
);
	typedef struct packed {
		logic enable;
		logic [BURST_WIDTH-1:0] burst;
		logic [MAXPKT_WIDTH-1:0] max_packet;
		logic active;
		logic [31:0] rdata;
	} regs_type;
	regs_type r;
	regs_type next_r;
	logic setup;
	logic wr;

	// decode shared by the error answer and the write strobe
	function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] a);
		return (a == CTRL_OFFSET) || (a == ARM_OFFSET) || (a == STATUS_OFFSET) || (a == COUNT_OFFSET);
	endfunction

	// zero wait states; writes land on the access edge
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & addr_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_mapped(paddr);
	assign prdata = r.rdata;
	assign enable = r.enable;
	assign burst = r.burst;
	assign max_packet = r.max_packet;
	assign active = r.active;

	// next register values
	always_comb
	begin
		next_r = r;
		// software arming below wins over the end-of-sequence clear
		if (hw_clear_active)
			next_r.active = 1'b0;
		if (wr)
		begin
			if (paddr == CTRL_OFFSET)
			begin
				next_r.enable = pwdata[CTRL_ENABLE_BIT];
				// burst frozen while configured
				// endpoint fields only change while disabled
				if (!r.enable)
				begin
					next_r.burst = pwdata[CTRL_BURST_LSB +: BURST_WIDTH];
					next_r.max_packet = pwdata[CTRL_MAXPKT_LSB +: MAXPKT_WIDTH];
				end
			end
			else if (paddr == ARM_OFFSET)
			begin
				if (pwdata[ARM_ACTIVE_BIT])
					next_r.active = 1'b1;
			end
		end
		// read data captured in setup so it comes from a flop in access
		if (setup)
		begin
			next_r.rdata = 32'h00000000;
			if (paddr == CTRL_OFFSET)
			begin
				next_r.rdata[CTRL_ENABLE_BIT] = r.enable;
				next_r.rdata[CTRL_BURST_LSB +: BURST_WIDTH] = r.burst;
				next_r.rdata[CTRL_MAXPKT_LSB +: MAXPKT_WIDTH] = r.max_packet;
			end
			else if (paddr == ARM_OFFSET)
				next_r.rdata[ARM_ACTIVE_BIT] = r.active;
			else if (paddr == STATUS_OFFSET)
				next_r.rdata = status_word;
			else if (paddr == COUNT_OFFSET)
				next_r.rdata = count_word;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '{enable: 1'b0, burst: BURST_RESET, max_packet: MAXPKT_RESET, active: 1'b0, rdata: 32'h00000000};
		else
			r <= next_r;
	end
endmodule // hbw_iso_regs

//--- hdl/hbw_len_check.sv
// payload length against maximum packet length comparator
`timescale 1ns/1ps
module hbw_len_check #(
	parameter int WIDTH = 11
) (
	input wire logic [WIDTH-1:0] len,
	input wire logic [WIDTH-1:0] max_len,
	output logic shorter,
	output logic exact,
	output logic longer
);
	// three-way compare, exactly one output high
	assign shorter = len < max_len;
	assign exact = len == max_len;
	assign longer = len > max_len;
endmodule // hbw_len_check

//--- hdl/hs_hbw_iso_in_pid_checker.sv
// high-bandwidth isochronous in pid sequence tracker with apb registers
`timescale 1ns/1ps
module hs_hbw_iso_in_pid_checker
	import hbw_iso_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic uframe_start,
	output logic in_token,
	input wire logic rsp_valid,
	input wire logic [3:0] rsp_pid,
	input wire logic [MAXPKT_WIDTH-1:0] rsp_len,
	input wire logic rsp_timeout,
	output logic td_advance,
	output logic [2:0] completion_code
);
	typedef struct packed {
		seq_state_type st;
		logic [1:0] cnt;
		logic td_advance;
		logic [2:0] code;
		logic [15:0] adv_count;
		logic [15:0] err_count;
	} track_type;
	track_type s;
	track_type next_s;
	logic enable;
	logic [BURST_WIDTH-1:0] burst;
	logic [MAXPKT_WIDTH-1:0] max_packet;
	logic active;
	logic [31:0] status_word;
	logic [31:0] count_word;
	logic shorter;
	logic exact;
	logic longer;
	logic [2:0] y_info;
	logic is_data;
	logic [1:0] y;
	logic restart;
	logic step_ok;
	logic take_start;
	logic take_next;
	logic end_seq;
	logic [2:0] end_code;

	// software side
	hbw_iso_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.hw_clear_active(s.td_advance),
		.status_word(status_word),
		.count_word(count_word),
		.enable(enable),
		.burst(burst),
		.max_packet(max_packet),
		.active(active)
	);

	hbw_len_check #(
		.WIDTH(MAXPKT_WIDTH)
	) u_len (
		.len(rsp_len),
		.max_len(max_packet),
		.shorter(shorter),
		.exact(exact),
		.longer(longer)
	);

	// response decode and qualifiers
	assign y_info = pid_value(rsp_pid);
	assign is_data = y_info[2];
	assign y = y_info[1:0];
	assign restart = uframe_start & enable & active & (s.st == st_idle);
	assign take_start = (s.st == st_start_wait) & rsp_valid & ~rsp_timeout;
	assign take_next = (s.st == st_next_wait) & rsp_valid & ~rsp_timeout;
	// step check by compare, no subtract
	// only 2->1 and 1->0 are legal steps, so no subtractor is needed
	assign step_ok = ((s.cnt == 2'h2) && (y == 2'h1)) || ((s.cnt == 2'h1) && (y == 2'h0));
	// token sent in each token state
	assign in_token = (s.st == st_start_tok) || (s.st == st_next_tok);
	assign td_advance = s.td_advance;
	assign completion_code = s.code;

	// status words for read-back
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[STATUS_STATE_LSB +: 3] = s.st;
		status_word[STATUS_CNT_LSB +: 2] = s.cnt;
		status_word[STATUS_CODE_LSB +: 3] = s.code;
		status_word[STATUS_ACTIVE_BIT] = active;
		count_word = 32'h00000000;
		count_word[COUNT_ADV_LSB +: 16] = s.adv_count;
		count_word[COUNT_ERR_LSB +: 16] = s.err_count;
	end

	// sequence tracker
	always_comb
	begin
		next_s = s;
		next_s.td_advance = 1'b0;
		end_seq = 1'b0;
		end_code = CODE_NONE;
		case (s.st)
			st_idle:
			begin
				// microframe restarts tracker
				// counter is a don't care here; cleared only for tidiness
				if (restart)
				begin
					next_s.st = st_start_tok;
					next_s.cnt = 2'h0;
				end
			end
			st_start_tok:
				next_s.st = st_start_wait;
			st_next_tok:
				next_s.st = st_next_wait;
			st_start_wait:
			begin
				if (rsp_timeout)
				begin
					end_seq = 1'b1;
					end_code = CODE_TRANSACTION_ERROR;
				end
				else if (rsp_valid)
				begin
					end_seq = 1'b1;
					end_code = CODE_TRANSACTION_ERROR;
					if (is_data && (y == 2'h0))
						end_code = longer ? CODE_BABBLE : CODE_SUCCESS;
					else if (is_data && (y < burst))
					begin
						if (longer)
							end_code = CODE_BABBLE;
						else if (exact)
						begin
							end_seq = 1'b0;
							next_s.cnt = y;
							next_s.st = st_next_tok;
						end
					end
				end
			end
			st_next_wait:
			begin
				if (rsp_timeout)
				begin
					end_seq = 1'b1;
					end_code = CODE_TRANSACTION_ERROR;
				end
				else if (rsp_valid)
				begin
					end_seq = 1'b1;
					end_code = CODE_TRANSACTION_ERROR;
					if (is_data && step_ok)
					begin
						if (longer)
							end_code = CODE_BABBLE;
						else if (y == 2'h1)
						begin
							if (exact)
							begin
								end_seq = 1'b0;
								next_s.cnt = 2'h1;
								next_s.st = st_next_tok;
							end
						end
						else
							end_code = CODE_SUCCESS;
					end
				end
			end
			default:
				next_s.st = st_idle;
		endcase
		if (end_seq)
		begin
			next_s.st = st_idle;
			next_s.td_advance = 1'b1;
			next_s.code = end_code;
			next_s.adv_count = s.adv_count + 16'h0001;
			if (end_code != CODE_SUCCESS)
				next_s.err_count = s.err_count + 16'h0001;
		end
		// disabling abandons the sequence without reporting, unless a response ends it in that same cycle
		if (!enable)
			next_s.st = st_idle;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '{st: st_idle, cnt: 2'h0, td_advance: 1'b0, code: CODE_NONE, adv_count: 16'h0000, err_count: 16'h0000};
		else
			s <= next_s;
	end

	// checks on the tracker
	AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn) restart |=> in_token ##1 !in_token)
		else $error("microframe start did not issue one token");
	AST_CFG_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
		$past(enable) && enable |-> $stable(burst) && $stable(max_packet))
		else $error("endpoint configuration changed while enabled");
	AST_START_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_start && is_data && (y != 2'h0) && (y < burst) && shorter
		|=> td_advance && completion_code == CODE_TRANSACTION_ERROR)
		else $error("short first data1/data2 not reported");
	AST_START_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_start && is_data && (y != 2'h0) && (y >= burst)
		|=> td_advance && completion_code == CODE_TRANSACTION_ERROR)
		else $error("start pid outside burst not reported");
	AST_START_DATA0: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_start && is_data && (y == 2'h0) && !longer
		|=> td_advance && completion_code == CODE_SUCCESS && s.st == st_idle)
		else $error("first data0 did not finish the microframe");
	AST_BABBLE: assert property (@(posedge pclk) disable iff (!presetn)
		enable && ((take_start && ((y == 2'h0) || (y < burst))) || (take_next && step_ok)) && is_data && longer
		|=> td_advance && completion_code == CODE_BABBLE)
		else $error("oversize payload not reported as babble");
	AST_CNT_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_start && is_data && (y != 2'h0) && (y < burst) && exact
		|=> !td_advance && s.cnt == $past(y) && in_token)
		else $error("counter not loaded from first pid");
	AST_TWICE_DATA2: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_next && s.cnt == 2'h2 && rsp_pid == PID_DATA2
		|=> td_advance && completion_code == CODE_TRANSACTION_ERROR)
		else $error("repeated data2 not reported");
	AST_JUMP: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_next && s.cnt == 2'h2 && rsp_pid == PID_DATA0
		|=> td_advance && completion_code == CODE_TRANSACTION_ERROR)
		else $error("data2 to data0 jump not reported");
	AST_REPEAT: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_next && s.cnt == 2'h1 && (rsp_pid == PID_DATA1 || rsp_pid == PID_DATA2)
		|=> td_advance && completion_code == CODE_TRANSACTION_ERROR)
		else $error("repeated pid at count one not reported");
	AST_NEXT_DATA1: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_next && s.cnt == 2'h2 && rsp_pid == PID_DATA1 && exact
		|=> !td_advance && s.cnt == 2'h1 && in_token ##1 s.st == st_next_wait)
		else $error("good follow-on data1 did not continue");
	AST_NEXT_DATA0: assert property (@(posedge pclk) disable iff (!presetn)
		enable && take_next && s.cnt == 2'h1 && rsp_pid == PID_DATA0 && !longer
		|=> td_advance && completion_code == CODE_SUCCESS ##1 !td_advance && s.st == st_idle)
		else $error("final data0 did not complete");
	AST_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn)
		enable && rsp_timeout && (s.st == st_start_wait || s.st == st_next_wait)
		|=> td_advance && completion_code == CODE_TRANSACTION_ERROR)
		else $error("timeout not reported");
	AST_ADV_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		td_advance |-> completion_code != CODE_NONE && s.st == st_idle ##1 !td_advance)
		else $error("advance without code or longer than a pulse");
	AST_ADV_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		td_advance |-> $past(s.st) == st_start_wait || $past(s.st) == st_next_wait)
		else $error("advance without a finished transaction");
endmodule // hs_hbw_iso_in_pid_checker

//--- pkg/hbw_iso_pkg.sv
// constants, types and pid decoding shared by the isochronous in sequence checker
package hbw_iso_pkg;
	// register byte offsets
	localparam int ADDR_WIDTH = 12;
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] ARM_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;
	localparam logic [11:0] COUNT_OFFSET = 12'h00C;
	// field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_BURST_LSB = 4;
	localparam int CTRL_MAXPKT_LSB = 16;
	localparam int ARM_ACTIVE_BIT = 0;
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_CNT_LSB = 8;
	localparam int STATUS_CODE_LSB = 16;
	localparam int STATUS_ACTIVE_BIT = 24;
	localparam int COUNT_ADV_LSB = 0;
	localparam int COUNT_ERR_LSB = 16;
	// field widths and reset values
	localparam int BURST_WIDTH = 2;
	localparam int MAXPKT_WIDTH = 11;
	localparam logic [1:0] BURST_RESET = 2'h1;
	localparam logic [10:0] MAXPKT_RESET = 11'h400;
	// data pid codes as seen on the wire
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [3:0] PID_DATA1 = 4'hB;
	localparam logic [3:0] PID_DATA2 = 4'h7;
	// completion codes handed to the completion-reporting logic
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_SUCCESS = 3'h1;
	localparam logic [2:0] CODE_TRANSACTION_ERROR = 3'h2;
	localparam logic [2:0] CODE_BABBLE = 3'h3;
	// sequence tracker states
	typedef enum logic [2:0] {st_idle, st_start_tok, st_start_wait, st_next_tok, st_next_wait} seq_state_type;
	// returns {is_data, value number}; anything but data0/1/2 is not a data pid
	function automatic logic [2:0] pid_value(input logic [3:0] pid);
		if (pid == PID_DATA0)
			return 3'h4;
		else if (pid == PID_DATA1)
			return 3'h5;
		else if (pid == PID_DATA2)
			return 3'h6;
		else
			return 3'h0;
	endfunction
endpackage
